//--- verilog/rrag_top.sv
/*
 ROM/RAM address generator of a 4-bit core with 10-bit instruction words.
 Assumes the core presents one decoded word per fetch_en pulse together
 with the word itself; ROM data for table fetch arrives one cycle later.
*/
// Operation
// [RL1] Indirect RAM address is bank, row and column concatenated, ten bits.
// [RL2] Direct RAM access takes two words; second word is the address.
// [RL3] Sixteen memory registers sit at RAM 040 upward.
// [RL4] Long jumps load all fourteen counter bits from the immediate.
// [RL5] ROM is 64 pages of 256 words; low byte selects word.
// [RL6] In-page jump replaces only the low eight counter bits.
// [RL7] In-page jump at a page's last word lands in the next page.
// [RL8] Zero-page call loads six low bits, clears upper eight.
// [RL9] Table jump target built from immediate, accumulator and aux.
// [RL10] Table fetch word bit 8 loads accumulator pair with low byte.
// [RL11] Table fetch word bit 9 loads both port registers with low byte.
// [RL12] Both flags set update accumulator pair and ports together.
// [RL13] Table fetch leaves counter on normal sequencing.
// [RL14] ROM and instruction words are ten bits wide.
// [RL15] Counter advances one per fetched word, second words included.
// [RL16] Table target is immediate, then accumulator, then aux; rest zero.
`timescale 1ns/1ps
`default_nettype none
module rrag_top
   import rrag_pkg::*;
#(
   parameter int PAGES = 64,
   parameter int PAGE_WORDS = 256
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic fetch_en,
   input wire logic [RRAG_IW-1:0] fetch_word,
   input wire rrag_req_s req,
   input wire rrag_regs_s regs,
   input wire logic [RRAG_IW-1:0] rom_data,
   output logic [RRAG_PCW-1:0] pc,
   output logic [RRAG_PCW-1:0] table_addr,
   output logic table_rd,
   output rrag_ram_s ram,
   output logic acc_we,
   output logic [RRAG_NIB-1:0] acc_out,
   output logic [RRAG_NIB-1:0] aux_out,
   output logic [RRAG_NIB-1:0] port_one_out,
   output logic [RRAG_NIB-1:0] port_two_out
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [RRAG_PCW-1:0] pc;
      logic second;                     // Next word is an operand
      logic fetch_pend;                 // Table word due this cycle
      logic acc_we;
      logic [RRAG_NIB-1:0] acc;
      logic [RRAG_NIB-1:0] aux;
      logic [RRAG_NIB-1:0] p1;
      logic [RRAG_NIB-1:0] p2;
   } rrag_state_s;

   rrag_state_s s_q;
   rrag_state_s s_d;
   logic rst_n;
   logic [RRAG_PCW-1:0] pc_inc;
   logic [RRAG_PCW-1:0] tbl;
   logic page_end;

   assign rst_n = s_q.rst_sync[1];
   assign pc_inc = s_q.pc + 14'h0001;
   assign page_end = (s_q.pc[RRAG_PGW-1:0] == RRAG_PAGE_LAST);
   // Table target: imm above acc above aux, upper bits clear
   assign tbl = {{(RRAG_PCW-RRAG_TIW-2*RRAG_NIB){1'b0}}, req.imm[RRAG_TIW-1:0],
                 regs.acc, regs.aux}; // RL9 RL16

   // ----------------------------------------------------------------
   // RAM address former
   // ----------------------------------------------------------------
   rrag_ram_addr u_ram (
      .op(req.op),
      .second_word(s_q.second),
      .word(fetch_word), // RL14
      .regs(regs),
      .mr_idx(req.mr_idx),
      .ram(ram)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
      s_d.fetch_pend = 1'b0;
      s_d.acc_we = 1'b0;
      // Table word returns: flag bits steer the low byte
      if (s_q.fetch_pend) begin
         if (rom_data[RRAG_FLAG_ACC]) begin // RL10 RL12
            s_d.acc_we = 1'b1;
            s_d.acc = rom_data[RRAG_NIB-1:0];
            s_d.aux = rom_data[2*RRAG_NIB-1:RRAG_NIB];
         end
         if (rom_data[RRAG_FLAG_PORT]) begin // RL11 RL12
            s_d.p1 = rom_data[RRAG_NIB-1:0];
            s_d.p2 = rom_data[2*RRAG_NIB-1:RRAG_NIB];
         end
      end
      if (fetch_en) begin
         s_d.pc = pc_inc; // RL15 RL13
         if (s_q.second) begin
            s_d.second = 1'b0; // RL15
         end else if (req.valid) begin
            case (req.op)
               RRAG_OP_RAM_DIR: begin
                  s_d.second = 1'b1; // RL2
               end
               RRAG_OP_LONG: begin
                  s_d.pc = req.imm; // RL4
               end
               RRAG_OP_INPAGE: begin
                  // Last word of page: page bits taken from pc+1
                  if (page_end) begin
                     s_d.pc = {pc_inc[RRAG_PCW-1:RRAG_PGW], req.imm[RRAG_PGW-1:0]}; // RL7
                  end else begin
                     s_d.pc = {s_q.pc[RRAG_PCW-1:RRAG_PGW], req.imm[RRAG_PGW-1:0]}; // RL6 RL5
                  end
               end
               RRAG_OP_ZPAGE: begin
                  s_d.pc = {{(RRAG_PCW-RRAG_ZPW){1'b0}}, req.imm[RRAG_ZPW-1:0]}; // RL8
               end
               RRAG_OP_TABLE_JMP: begin
                  s_d.pc = tbl; // RL9
               end
               RRAG_OP_TABLE_FETCH: begin
                  s_d.fetch_pend = 1'b1; // RL13
               end
               default: begin
                  s_d.second = 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else if (!rst_n) begin
         s_q <= '0;
         s_q.rst_sync <= {s_q.rst_sync[0], 1'b1};
         s_q.pc <= RRAG_PC_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs
   assign pc = s_q.pc;
   assign table_addr = tbl;
   assign table_rd = fetch_en & req.valid & ~s_q.second & (req.op == RRAG_OP_TABLE_FETCH);
   assign acc_we = s_q.acc_we;
   assign acc_out = s_q.acc;
   assign aux_out = s_q.aux;
   assign port_one_out = s_q.p1;
   assign port_two_out = s_q.p2;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   long_load_a: assert property (@(posedge clk) disable iff (!rst_n) // RL4
      fetch_en && req.valid && !s_q.second && req.op == RRAG_OP_LONG |=> pc == $past(req.imm))
      else $error("long jump target not loaded");
   in_page_a: assert property (@(posedge clk) disable iff (!rst_n) // RL6
      fetch_en && req.valid && !s_q.second && req.op == RRAG_OP_INPAGE && !page_end
      |=> pc[13:8] == $past(s_q.pc[13:8]) && pc[7:0] == $past(req.imm[7:0]))
      else $error("in-page jump wrong");
   page_cross_a: assert property (@(posedge clk) disable iff (!rst_n) // RL7
      fetch_en && req.valid && !s_q.second && req.op == RRAG_OP_INPAGE && page_end
      |=> pc[13:8] == $past(s_q.pc[13:8]) + 6'h01)
      else $error("boundary jump not in next page");
   zero_page_a: assert property (@(posedge clk) disable iff (!rst_n) // RL8
      fetch_en && req.valid && !s_q.second && req.op == RRAG_OP_ZPAGE
      |=> pc[13:6] == 8'h00 && pc[5:0] == $past(req.imm[5:0]))
      else $error("zero-page call wrong");
   table_jump_a: assert property (@(posedge clk) disable iff (!rst_n) // RL16
      fetch_en && req.valid && !s_q.second && req.op == RRAG_OP_TABLE_JMP
      |=> pc == {2'h0, $past(req.imm[3:0]), $past(regs.acc), $past(regs.aux)})
      else $error("table jump target wrong");
   fetch_seq_a: assert property (@(posedge clk) disable iff (!rst_n) // RL13
      fetch_en && req.valid && !s_q.second && req.op == RRAG_OP_TABLE_FETCH
      |=> pc == $past(s_q.pc) + 14'h0001)
      else $error("table fetch moved counter");
   acc_load_a: assert property (@(posedge clk) disable iff (!rst_n) // RL10
      s_q.fetch_pend && rom_data[8] |=> acc_we && {aux_out, acc_out} == $past(rom_data[7:0]))
      else $error("accumulator pair not loaded");
   port_load_a: assert property (@(posedge clk) disable iff (!rst_n) // RL11
      s_q.fetch_pend && rom_data[9]
      |=> {port_two_out, port_one_out} == $past(rom_data[7:0]))
      else $error("port registers not loaded");
   port_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // RL12
      !s_q.fetch_pend |=> $stable(port_one_out) && $stable(port_two_out))
      else $error("ports changed without fetch");
   direct_ram_a: assert property (@(posedge clk) disable iff (!rst_n) // RL2
      fetch_en && req.valid && !s_q.second && req.op == RRAG_OP_RAM_DIR |=> s_q.second)
      else $error("direct access lost operand word");
endmodule
`default_nettype wire

//--- common/rrag_pkg.sv
/*
 Package of the ROM/RAM address generator: widths, RAM window, opcode
 classes of the address logic and the carrier structs.
 Assumes a core that decodes instructions into the operation class below.
*/
package rrag_pkg;

   // ----------------------------------------------------------------
   // Widths and map
   // ----------------------------------------------------------------
   localparam int RRAG_IW = 10;                 // Instruction / ROM word
   localparam int RRAG_PCW = 14;                // Program counter
   localparam int RRAG_RAW = 10;                // RAM address
   localparam int RRAG_PGW = 8;                 // Word-in-page bits
   localparam int RRAG_ZPW = 6;                 // Zero-page target bits
   localparam int RRAG_TIW = 4;                 // Table immediate bits
   localparam int RRAG_NIB = 4;                 // Accumulator width
   localparam int RRAG_MRW = 4;                 // Memory-register index
   localparam logic [RRAG_RAW-1:0] RRAG_MR_BASE = 10'h040;
   localparam logic [RRAG_PGW-1:0] RRAG_PAGE_LAST = 8'hff;
   localparam int RRAG_FLAG_ACC = 8;            // Load accumulator pair
   localparam int RRAG_FLAG_PORT = 9;           // Load port registers
   localparam logic [RRAG_PCW-1:0] RRAG_PC_RESET = 14'h0000;

   // ----------------------------------------------------------------
   // Operation classes
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      RRAG_OP_SEQ,          // Plain instruction, one word
      RRAG_OP_RAM_IND,      // RAM access via bank/row/column
      RRAG_OP_RAM_DIR,      // Two-word direct RAM access
      RRAG_OP_MEMREG,       // load_acc_from_memreg / swap_acc_memreg
      RRAG_OP_LONG,         // long_jump, long_branch, long_subroutine_jump
      RRAG_OP_INPAGE,       // in_page_jump
      RRAG_OP_ZPAGE,        // zero_page_subroutine_jump
      RRAG_OP_TABLE_JMP,    // table_jump
      RRAG_OP_TABLE_FETCH   // rom_table_fetch
   } rrag_op_e;

   // Decoded request from the core
   typedef struct packed {
      logic valid;
      rrag_op_e op;
      logic [RRAG_PCW-1:0] imm;        // Immediate, right-aligned
      logic [RRAG_MRW-1:0] mr_idx;     // Memory-register index
   } rrag_req_s;

   // Core register view
   typedef struct packed {
      logic [1:0] bank;                // ram_bank_select
      logic [3:0] row;                 // ram_row_sel
      logic [3:0] col;                 // ram_column_sel
      logic [RRAG_NIB-1:0] acc;
      logic [RRAG_NIB-1:0] aux;        // aux_accumulator
   } rrag_regs_s;

   // RAM address answer
   typedef struct packed {
      logic valid;
      logic [RRAG_RAW-1:0] addr;
   } rrag_ram_s;

endpackage

//--- verilog/rrag_ram_addr.sv
/*
 RAM address former: picks indirect, direct or memory-register address.
 Assumes the direct operand word arrives with the second fetched word.
*/
`timescale 1ns/1ps
`default_nettype none
module rrag_ram_addr
   import rrag_pkg::*;
(
   input wire rrag_op_e op,
   input wire logic second_word,
   input wire logic [RRAG_IW-1:0] word,
   input wire rrag_regs_s regs,
   input wire logic [RRAG_MRW-1:0] mr_idx,
   output rrag_ram_s ram
);
   // ----------------------------------------------------------------
   // Address selection
   // ----------------------------------------------------------------
   // Operand word wins: its decode is meaningless, so op is not looked at
   always_comb begin
      ram = '0;
      if (second_word) begin
         ram.valid = 1'b1;
         ram.addr = word; // RL2
      end else begin
         case (op)
            RRAG_OP_RAM_IND: begin
               ram.valid = 1'b1;
               ram.addr = {regs.bank, regs.row, regs.col}; // RL1
            end
            RRAG_OP_MEMREG: begin
               ram.valid = 1'b1;
               ram.addr = RRAG_MR_BASE | {{(RRAG_RAW-RRAG_MRW){1'b0}}, mr_idx}; // RL3
            end
            default: begin
               ram = '0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

//--- tb/rrag_rom_model.sv
/*
 Program ROM model answering table reads of the address generator.
 Assumes table_rd is a one-cycle request; data stands for one cycle only.
*/
`timescale 1ns/1ps
`default_nettype none
module rrag_rom_model
   import rrag_pkg::*;
(
   input wire logic clk,
   input wire logic table_rd,
   input wire logic [RRAG_PCW-1:0] table_addr,
   output logic [RRAG_IW-1:0] rom_data
);
   // ----------------------------------------------------------------
   // Table contents and read port
   // ----------------------------------------------------------------
   // Ten-bit word; flag bits follow the low address bits
   function automatic logic [RRAG_IW-1:0] word_at(input logic [RRAG_PCW-1:0] a);
      return {a[1:0], a[7:0] ^ 8'h3c};
   endfunction

   // Answer next cycle; without a read the last data is inverted each cycle
   always @(posedge clk) begin
      if (table_rd) begin
         rom_data <= word_at(table_addr);
      end else begin
         rom_data <= ~rom_data;
      end
   end
endmodule
`default_nettype wire

//--- tb/rrag_top_tb.sv
/*
 Self-checking bench of the ROM/RAM address generator.
 Assumes rrag_pkg and the ROM model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module rrag_top_tb
   import rrag_pkg::*;
;
   logic clk = 1'b0, resetn = 1'b0, fetch_en = 1'b0, took = 1'b0;
   logic [9:0] fetch_word = 10'h000, rom_data;
   rrag_req_s req = '0;
   rrag_regs_s regs = '0;
   logic [13:0] pc, table_addr, m_pc = 14'h0000;
   logic table_rd, acc_we;
   rrag_ram_s ram;
   logic [3:0] acc_out, aux_out, p1, p2;
   logic [13:0] pcq[$];
   logic [7:0] accq[$];
   logic [7:0] e_port = 8'h00;
   int fails = 0, total_checks = 0;

   rrag_top #(.PAGES(64), .PAGE_WORDS(256)) dut_u (.clk(clk), .resetn(resetn),
      .fetch_en(fetch_en), .fetch_word(fetch_word), .req(req), .regs(regs),
      .rom_data(rom_data), .pc(pc), .table_addr(table_addr), .table_rd(table_rd),
      .ram(ram), .acc_we(acc_we), .acc_out(acc_out), .aux_out(aux_out),
      .port_one_out(p1), .port_two_out(p2));
   rrag_rom_model rom_u (.clk(clk), .table_rd(table_rd), .table_addr(table_addr),
      .rom_data(rom_data));

   always #5 clk = ~clk;

   // ----------------------------------------------------------------
   // Compare, finish
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Drivers
   // ----------------------------------------------------------------
   // One fetched word; notes expected counter, checks RAM answer
   task automatic fetch(input logic v, input rrag_op_e op, input logic [13:0] imm,
                        input logic [9:0] w, input logic [3:0] mr, input logic sec);
      logic [13:0] n;
      logic [9:0] rw;
      fetch_en <= 1'b1;
      req <= '{valid: v, op: op, imm: imm, mr_idx: mr};
      fetch_word <= w;
      n = m_pc + 14'h1;
      if (v && !sec) begin
         case (op)
            RRAG_OP_LONG: n = imm;
            RRAG_OP_INPAGE: n = (m_pc[7:0] == 8'hff) ? {m_pc[13:8] + 6'h1, imm[7:0]} :
                                                     {m_pc[13:8], imm[7:0]};
            RRAG_OP_ZPAGE: n = {8'h00, imm[5:0]};
            RRAG_OP_TABLE_JMP: n = {2'b00, imm[3:0], regs.acc, regs.aux};
            default: ;
         endcase
      end
      pcq.push_back(n);
      m_pc = n;
      #1;
      if (sec) check({ram.valid, ram.addr}, {1'b1, w});
      else if (v && op == RRAG_OP_RAM_IND)
         check({ram.valid, ram.addr}, {1'b1, regs.bank, regs.row, regs.col});
      else if (v && op == RRAG_OP_MEMREG)
         check({ram.valid, ram.addr}, {1'b1, RRAG_MR_BASE | {6'h00, mr}});
      else if (v && op == RRAG_OP_TABLE_FETCH) begin
         check({table_rd, table_addr}, {1'b1, 2'b00, imm[3:0], regs.acc, regs.aux});
         rw = {regs.aux[1:0], {regs.acc, regs.aux} ^ 8'h3c};
         if (rw[8]) accq.push_back(rw[7:0]);
         if (rw[9]) e_port = rw[7:0];
      end
      @(posedge clk);
   endtask

   task automatic idle(input rrag_regs_s r);
      fetch_en <= 1'b0;
      req <= '0;
      regs <= r;
      @(posedge clk);
   endtask

   // ----------------------------------------------------------------
   // Result watcher
   // ----------------------------------------------------------------
   always @(posedge clk) took <= fetch_en;

   // Oldest note against each counter update and accumulator load
   always @(negedge clk) begin
      if (took && pcq.size() > 0) check(pc, pcq.pop_front());
      if (acc_we) check({aux_out, acc_out}, accq.size() > 0 ? accq.pop_front() : 9'h1ff);
   end

   initial begin
      #200000;
      fails++;
      close_out();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h71cb));
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      check(pc, RRAG_PC_RESET);
      for (int i = 0; i < 4; i++)
         fetch(1'b1, RRAG_OP_LONG, (i == 3) ? 14'h3fff : 14'($urandom), 10'h0, 4'h0, 1'b0);
      $display("Test long jumps done");
      // Page-end jumps, last one wraps from the top page
      for (int i = 0; i < 2; i++) begin
         fetch(1'b1, RRAG_OP_LONG, i ? 14'h3ffe : 14'h12fe, 10'h0, 4'h0, 1'b0);
         fetch(1'b1, RRAG_OP_SEQ, 14'h0, 10'h0, 4'h0, 1'b0);
         fetch(1'b1, RRAG_OP_INPAGE, 14'h0056 + 14'(i), 10'h0, 4'h0, 1'b0);
         fetch(1'b1, RRAG_OP_INPAGE, 14'h2a34, 10'h0, 4'h0, 1'b0);
      end
      fetch(1'b1, RRAG_OP_ZPAGE, 14'h3fff, 10'h0, 4'h0, 1'b0);
      fetch(1'b1, RRAG_OP_ZPAGE, 14'h3fe5, 10'h0, 4'h0, 1'b0);
      idle('{bank: 2'h1, row: 4'h2, col: 4'h3, acc: 4'h5, aux: 4'ha});
      fetch(1'b1, RRAG_OP_TABLE_JMP, 14'h3ff7, 10'h0, 4'h0, 1'b0);
      $display("Test branches done");
      idle(rrag_regs_s'(18'($urandom)));
      fetch(1'b1, RRAG_OP_RAM_IND, 14'h0, 10'h0, 4'h0, 1'b0);
      for (int i = 0; i < 16; i++) fetch(1'b1, RRAG_OP_MEMREG, 14'h0, 10'h0, 4'(i), 1'b0);
      fetch(1'b1, RRAG_OP_RAM_DIR, 14'h0, 10'h0, 4'h0, 1'b0);
      fetch(1'b1, RRAG_OP_LONG, 14'h2222, 10'h3ff, 4'h0, 1'b1);
      fetch(1'b0, RRAG_OP_LONG, 14'h1111, 10'h0, 4'h0, 1'b0);
      $display("Test ram addressing done");
      // All four flag combinations of the table word
      for (int i = 0; i < 4; i++) begin
         idle('{bank: 2'h0, row: 4'h0, col: 4'h0, acc: 4'($urandom), aux: 4'(i)});
         fetch(1'b1, RRAG_OP_TABLE_FETCH, 14'($urandom), 10'h0, 4'h0, 1'b0);
         idle(regs);
         idle(regs);
         check({p2, p1}, e_port);
      end
      $display("Test table fetch done");
      repeat (2) idle(regs);
      check(pcq.size() + accq.size(), 0);
      close_out();
   end
endmodule
`default_nettype wire
